// file: hdl/cbc_cycle_seq.sv
// Purpose: Turns one CPU access into bus cycles of 1, 2 or 3+m states
// Assumes: Requests, configuration and read data are synchronous to clk
// Notes: A word over an 8-bit path becomes two byte cycles, even byte first
`timescale 1ns/1ps
module cbc_cycle_seq
    import cbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // CPU request
    input wire logic cpuReq,
    input wire logic [1:0] cpuTarget,
    input wire logic [ADDR_W-1:0] cpuAddr,
    input wire logic cpuWrite,
    input wire logic cpuWord,
    input wire logic [DATA_W-1:0] cpuWdata,
    // CPU answer
    output logic cpuReady,
    output logic cpuDone,
    output logic [DATA_W-1:0] cpuRdata,
    // Path configuration
    input wire logic periphWide,
    input wire logic extWide,
    input wire logic extThreeState,
    input wire logic [WAIT_W-1:0] extWaitCount,
    // Target selects
    output logic memSel,
    output logic periphSel,
    output logic extSel,
    // Shared bus
    output logic busStart,
    output logic [ADDR_W-1:0] busAddr,
    output logic busWrite,
    output logic [1:0] busLanes,
    output logic [DATA_W-1:0] busWdata,
    input wire logic [DATA_W-1:0] busRdata
);

    // Sequencer state
    cbc_seq_e state_q;                      // Idle or running a bus cycle
    logic accept;                           // Request taken this edge
    logic lastState;                        // Final state of the current bus cycle
    logic moreCycles;                       // A second byte cycle still follows

    // Latched access
    logic wide_q;                           // Path width for this access
    logic word_q;                           // Word transfer requested
    logic write_q;                          // Direction
    logic secondByte_q;                     // Running the lower-byte cycle
    logic [LEN_W-1:0] len_q;                // States per bus cycle, kept for reload
    logic [DATA_W-1:0] wdata_q;             // Write data held for the second cycle

    // Decoded for the incoming request
    logic reqWide;                          // Width of the addressed path
    logic [LEN_W-1:0] reqLen;               // States per bus cycle
    logic [LEN_W-1:0] timerLoad;            // Value handed to the timer
    logic timerStart;                       // Start of any bus cycle

    // Registered outputs
    logic ready_q;
    logic done_q;
    logic [DATA_W-1:0] rdata_q;
    logic memSel_q;
    logic periphSel_q;
    logic extSel_q;
    logic busStart_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] lanes_q;
    logic [DATA_W-1:0] busWdata_q;
    logic busWrite_q;                       // Direction shown on the bus

    assign accept = (state_q == SEQ_IDLE) && cpuReq;
    assign moreCycles = word_q && !wide_q && !secondByte_q;

    // Path width of the addressed target
    always_comb
    begin
        case (cpuTarget)
            TGT_MEM: reqWide = 1'b1;
            TGT_PERIPH: reqWide = periphWide;
            TGT_EXT: reqWide = extWide;
            default: reqWide = 1'b1;
        endcase
    end

    // States per bus cycle of the addressed target
    always_comb
    begin
        case (cpuTarget)
            TGT_MEM: reqLen = LEN_MEM;
            TGT_PERIPH: reqLen = LEN_PERIPH;
            TGT_EXT:
            begin
                // Waits are added only in three-state mode
                if (extThreeState)
                begin
                    reqLen = LEN_EXT_THREE + {1'b0, extWaitCount};
                end
                else
                begin
                    reqLen = LEN_EXT_TWO;
                end
            end
            default: reqLen = LEN_MEM;
        endcase
    end

    // Timer counts the states after the first; the second byte reuses the length
    assign timerStart = accept || (state_q == SEQ_BUS && lastState && moreCycles);
    assign timerLoad = accept ? reqLen - LEN_MEM : len_q - LEN_MEM;

    cbc_state_timer u_timer
    (
        .clk(clk),
        .rst_b(rst_b),
        .load(timerStart),
        .loadVal(timerLoad),
        .last(lastState)
    );

    // Sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= SEQ_IDLE;
        end
        else
        begin
            case (state_q)
                SEQ_IDLE:
                begin
                    if (cpuReq)
                    begin
                        state_q <= SEQ_BUS;
                    end
                end
                SEQ_BUS:
                begin
                    // Leave after the final state of the final cycle
                    if (lastState && !moreCycles)
                    begin
                        state_q <= SEQ_IDLE;
                    end
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end

    // Access attributes held for the whole access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wide_q <= 1'b1;
            word_q <= 1'b0;
            write_q <= 1'b0;
            len_q <= LEN_MEM;
            wdata_q <= DATA_RESET;
        end
        else if (accept)
        begin
            wide_q <= reqWide;
            word_q <= cpuWord;
            write_q <= cpuWrite;
            len_q <= reqLen;
            wdata_q <= cpuWdata;
        end
    end

    // Byte phase of an 8-bit word transfer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secondByte_q <= 1'b0;
        end
        else if (accept)
        begin
            secondByte_q <= 1'b0;
        end
        else if (state_q == SEQ_BUS && lastState && moreCycles)
        begin
            secondByte_q <= 1'b1;
        end
    end

    // Target selects stay up across both byte cycles
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            memSel_q <= 1'b0;
            periphSel_q <= 1'b0;
            extSel_q <= 1'b0;
        end
        else if (accept)
        begin
            memSel_q <= (cpuTarget == TGT_MEM);
            periphSel_q <= (cpuTarget == TGT_PERIPH);
            extSel_q <= (cpuTarget == TGT_EXT) || (cpuTarget == 2'h3);
        end
        else if (state_q == SEQ_BUS && lastState && !moreCycles)
        begin
            memSel_q <= 1'b0;
            periphSel_q <= 1'b0;
            extSel_q <= 1'b0;
        end
    end

    // Address, lanes and write data for each bus cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q <= ADDR_RESET;
            lanes_q <= LANES_NONE;
            busWdata_q <= DATA_RESET;
            busWrite_q <= 1'b0;
        end
        else if (accept)
        begin
            busWrite_q <= cpuWrite;
            if (cpuWord && reqWide)
            begin
                // Whole word in one cycle
                addr_q <= {cpuAddr[ADDR_W-1:1], 1'b0};
                lanes_q <= LANES_BOTH;
                busWdata_q <= cpuWdata;
            end
            else if (cpuWord)
            begin
                // Even address carries the upper byte first
                addr_q <= {cpuAddr[ADDR_W-1:1], 1'b0};
                lanes_q <= LANES_LOW;
                busWdata_q <= {8'h00, cpuWdata[15:8]};
            end
            else if (reqWide)
            begin
                // Byte on a 16-bit path: even byte on the upper lane
                addr_q <= cpuAddr;
                lanes_q <= cpuAddr[0] ? LANES_LOW : LANES_HIGH;
                busWdata_q <= cpuAddr[0] ? {8'h00, cpuWdata[7:0]} : {cpuWdata[7:0], 8'h00};
            end
            else
            begin
                // Byte on an 8-bit path uses the low lane
                addr_q <= cpuAddr;
                lanes_q <= LANES_LOW;
                busWdata_q <= {8'h00, cpuWdata[7:0]};
            end
        end
        else if (state_q == SEQ_BUS && lastState && moreCycles)
        begin
            // Odd address carries the lower byte second
            addr_q <= {addr_q[ADDR_W-1:1], 1'b1};
            busWdata_q <= {8'h00, wdata_q[7:0]};
        end
        else if (state_q == SEQ_BUS && lastState)
        begin
            lanes_q <= LANES_NONE;
        end
    end

    // Read data captured in the final state of each bus cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= DATA_RESET;
        end
        else if (state_q == SEQ_BUS && lastState && !write_q)
        begin
            if (word_q && wide_q)
            begin
                rdata_q <= busRdata;
            end
            else if (word_q && !secondByte_q)
            begin
                rdata_q <= {busRdata[7:0], 8'h00};
            end
            else if (word_q)
            begin
                rdata_q <= {rdata_q[15:8], busRdata[7:0]};
            end
            else if (wide_q && !addr_q[0])
            begin
                rdata_q <= {8'h00, busRdata[15:8]};
            end
            else
            begin
                rdata_q <= {8'h00, busRdata[7:0]};
            end
        end
    end

    // Handshake toward the CPU and bus-cycle start marker
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ready_q <= 1'b1;
            done_q <= 1'b0;
            busStart_q <= 1'b0;
        end
        else
        begin
            // Busy from acceptance to completion
            ready_q <= (state_q == SEQ_BUS) ? (lastState && !moreCycles) : !cpuReq;
            done_q <= (state_q == SEQ_BUS) && lastState && !moreCycles;
            busStart_q <= timerStart;
        end
    end

    // Every output straight from a flip-flop
    assign cpuReady = ready_q;
    assign cpuDone = done_q;
    assign cpuRdata = rdata_q;
    assign memSel = memSel_q;
    assign periphSel = periphSel_q;
    assign extSel = extSel_q;
    assign busStart = busStart_q;
    assign busAddr = addr_q;
    assign busWrite = busWrite_q;
    assign busLanes = lanes_q;
    assign busWdata = busWdata_q;

endmodule : cbc_cycle_seq

// file: hdl/cbc_pkg.sv
// Purpose: Shared constants and types for the CPU bus cycle sequencer
// Assumes: One system clock; one clock period equals one bus state
// Notes: Lengths are in states; the wait count m only stretches 3-state cycles
package cbc_pkg;

    // Clock and state timing
    localparam int CLK_PERIOD_NS = 5;          // 200 MHz system clock
    localparam int STATE_NS = 5;               // One state is one clock period
    localparam int CYCLES_PER_STATE = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int ADDR_W = 24;                // CPU address width
    localparam int DATA_W = 16;                // Widest data path
    localparam int LEN_W = 4;                  // Wide enough for 3 + m with m up to 7
    localparam int WAIT_W = 3;                 // Width of the wait-state count m

    // Target codes on the CPU request
    localparam logic [1:0] TGT_MEM = 2'h0;     // On-chip memory
    localparam logic [1:0] TGT_PERIPH = 2'h1;  // On-chip peripheral registers
    localparam logic [1:0] TGT_EXT = 2'h2;     // External address space

    // Bus cycle lengths in states
    localparam logic [LEN_W-1:0] LEN_MEM = 4'h1;
    localparam logic [LEN_W-1:0] LEN_PERIPH = 4'h2;
    localparam logic [LEN_W-1:0] LEN_EXT_TWO = 4'h2;
    localparam logic [LEN_W-1:0] LEN_EXT_THREE = 4'h3;

    // Byte lane enables
    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_LOW = 2'h1;
    localparam logic [1:0] LANES_HIGH = 2'h2;
    localparam logic [1:0] LANES_BOTH = 2'h3;

    // Reset values
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
    localparam logic [LEN_W-1:0] CNT_RESET = 4'h0;

    // Sequencer states, one-hot
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b01,
        SEQ_BUS = 2'b10
    } cbc_seq_e;

endpackage : cbc_pkg

// file: hdl/cbc_state_timer.sv
// Purpose: Counts the states of one bus cycle
// Assumes: load is a single-cycle pulse at the start of each bus cycle
// Notes: last is high during the final state of the loaded cycle
`timescale 1ns/1ps
module cbc_state_timer
    import cbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [LEN_W-1:0] loadVal,   // States remaining after the first
    // Status
    output logic last
);

    logic [LEN_W-1:0] cnt_q;                // States still to run

    // Down counter, one step per state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= CNT_RESET;
        end
        else if (load)
        begin
            cnt_q <= loadVal;
        end
        else if (cnt_q != CNT_RESET)
        begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // Final state when nothing remains
    assign last = (cnt_q == CNT_RESET);

endmodule : cbc_state_timer

// file: sim/cbc_far_model.sv
// Purpose: Memory, register and external device answering the bus
// Assumes: Byte at address a holds a[7:0] ^ a5
// Notes: Replies at once; waits come from the sequencer's own count
`timescale 1ns/1ps
module cbc_far_model
    import cbc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus from sequencer
    input wire logic anySel,
    input wire logic narrow,
    input wire logic [ADDR_W-1:0] busAddr,
    // Read data
    output logic [DATA_W-1:0] busRdata
);
    logic [DATA_W-1:0] junk_q = 16'h0f0f; // Toggles while deselected

    // Idle lines must not keep the last value
    always_ff @(posedge clk)
        junk_q <= ~busRdata;

    // Reply path
    always_comb
    begin
        if (!anySel)
            busRdata = junk_q;
        else if (narrow)
            busRdata = {~busAddr[7:0], busAddr[7:0] ^ 8'ha5};
        else
            busRdata = {busAddr[7:1], 1'b0, busAddr[7:1], 1'b1} ^ 16'ha5a5;
    end
endmodule : cbc_far_model

// file: sim/cbc_seq_monitor.sv
// Purpose: Timing checker for the bus cycle sequencer
// Assumes: Requests are one-cycle pulses taken while cpuReady is high
// Notes: A counter tracks the state index inside each access
`timescale 1ns/1ps
module cbc_seq_monitor
    import cbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // CPU side
    input wire logic cpuReq,
    input wire logic [1:0] cpuTarget,
    input wire logic cpuWord,
    input wire logic cpuReady,
    input wire logic cpuDone,
    // Configuration
    input wire logic periphWide,
    input wire logic extWide,
    input wire logic extThreeState,
    input wire logic [WAIT_W-1:0] extWaitCount,
    // Bus side
    input wire logic memSel,
    input wire logic busStart,
    input wire logic [ADDR_W-1:0] busAddr
);
    logic take; // Request taken at this edge
    logic narrow; // Word over an 8-bit path
    logic [5:0] len; // States of one bus cycle
    logic [5:0] cnt_q; // State index inside the access
    logic [5:0] tot_q; // Expected states of the access

    assign take = cpuReq && cpuReady;
    assign narrow = cpuWord && ((cpuTarget == TGT_PERIPH && !periphWide)
        || (cpuTarget == TGT_EXT && !extWide));
    assign len = (cpuTarget == TGT_MEM) ? 6'h1
        : (cpuTarget == TGT_EXT && extThreeState) ? 6'h3 + 6'(extWaitCount) : 6'h2;

    // State index; wraps only if done never comes, which then fails below
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 6'h0;
        else if (take)
            cnt_q <= 6'h1;
        else if (cpuDone)
            cnt_q <= 6'h0;
        else if (cnt_q != 6'h0)
            cnt_q <= cnt_q + 6'h1;
    end

    // Expected total, doubled for a split word
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tot_q <= 6'h0;
        else if (take)
            tot_q <= narrow ? len << 1 : len;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    state_count_a: assert property (cnt_q != 6'h0 |-> cpuDone == (cnt_q == tot_q + 6'h1))
        else $error("access length differs from expected");
    busy_not_ready_a: assert property (cnt_q != 6'h0 && !cpuDone |-> !cpuReady)
        else $error("ready high during an access");
    mem_one_state_a: assert property (take && cpuTarget == TGT_MEM |=> memSel && busStart ##1 cpuDone)
        else $error("memory access not one state");
    periph_two_a: assert property (take && cpuTarget == TGT_PERIPH && !narrow
        |=> busStart ##1 !busStart && !cpuDone ##1 cpuDone)
        else $error("peripheral access not two states");
    narrow_split_a: assert property (take && narrow && !(cpuTarget == TGT_EXT && extThreeState)
        |=> busStart ##2 busStart ##2 cpuDone)
        else $error("narrow word not two byte cycles");
    three_state_a: assert property (take && cpuTarget == TGT_EXT && extThreeState
        && extWaitCount == 3'h0 && !narrow |=> busStart ##1 !busStart [*2] ##1 cpuDone)
        else $error("three-state access length wrong");
    two_state_ext_a: assert property (take && cpuTarget == TGT_EXT && !extThreeState
        && extWide |-> ##3 cpuDone)
        else $error("two-state external access stretched");
    even_first_a: assert property (busStart && $past(take) && $past(cpuWord) |-> !busAddr[0])
        else $error("word does not start at even address");
    odd_second_a: assert property (busStart && cnt_q > 6'h1 |-> busAddr[0])
        else $error("second byte cycle not at odd address");

    // Main scenarios
    cover property (take && cpuTarget == TGT_MEM);
    cover property (take && narrow && extThreeState && cpuTarget == TGT_EXT);
    cover property (cpuDone && take);
endmodule : cbc_seq_monitor

bind cbc_cycle_seq cbc_seq_monitor u_mon (.clk, .rst_b, .cpuReq, .cpuTarget, .cpuWord,
    .cpuReady, .cpuDone, .periphWide, .extWide, .extThreeState, .extWaitCount, .memSel,
    .busStart, .busAddr);

// file: sim/tb_cpu_bus_cycle_timing.sv
// Purpose: Self-checking bench for the bus cycle sequencer
// Assumes: Inputs change on the falling edge
// Notes: Row table first, then a reset in mid-access
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin nFail++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_cpu_bus_cycle_timing;
    import cbc_pkg::*;
    typedef struct {logic [1:0] tgt; logic wide; logic three; logic [2:0] m; logic word;
        logic wr; logic [23:0] addr; int t;} cbc_row_s;

    logic clk = 1'b0;
    logic rst_b, cpuReq, cpuWrite, cpuWord, periphWide, extWide, extThreeState;
    logic [1:0] cpuTarget;
    logic [2:0] extWaitCount;
    logic [23:0] cpuAddr, busAddr;
    logic [15:0] cpuWdata, cpuRdata, busWdata, busRdata;
    logic cpuReady, cpuDone, memSel, periphSel, extSel, busStart, busWrite, narrow;
    logic [1:0] busLanes;
    int nFail = 0;
    int checks = 0;
    // Target, width, 3-state, m, word, write, address, states
    cbc_row_s rows [15] = '{
        '{TGT_MEM, 1, 0, 0, 0, 0, 24'h000013, 1}, '{TGT_MEM, 1, 0, 0, 1, 1, 24'h000020, 1},
        '{TGT_PERIPH, 0, 0, 0, 0, 0, 24'hffff05, 2}, '{TGT_PERIPH, 0, 0, 0, 1, 0, 24'hffff10, 4},
        '{TGT_PERIPH, 1, 0, 0, 1, 1, 24'hffff22, 2}, '{TGT_EXT, 0, 0, 0, 0, 1, 24'h200031, 2},
        '{TGT_EXT, 0, 0, 0, 1, 1, 24'h200040, 4}, '{TGT_EXT, 0, 1, 2, 1, 0, 24'h200052, 10},
        '{TGT_EXT, 0, 1, 0, 0, 0, 24'h200063, 3}, '{TGT_EXT, 1, 0, 5, 1, 0, 24'h400070, 2},
        '{TGT_EXT, 1, 1, 7, 1, 1, 24'h400084, 10}, '{TGT_EXT, 1, 1, 0, 0, 0, 24'h400095, 3},
        '{TGT_EXT, 1, 1, 3, 1, 0, 24'h4000a6, 6}, '{TGT_MEM, 1, 0, 0, 0, 1, 24'h000014, 1},
        '{TGT_PERIPH, 1, 0, 0, 0, 0, 24'hffff34, 2}};

    // 200 MHz
    always #2.5 clk = ~clk;

    // Far side sees the path width of the current target
    assign narrow = (cpuTarget == TGT_MEM) ? 1'b0
        : (cpuTarget == TGT_PERIPH) ? !periphWide : !extWide;

    cbc_cycle_seq DUT (.clk(clk), .rst_b(rst_b), .cpuReq(cpuReq), .cpuTarget(cpuTarget),
        .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuWord(cpuWord), .cpuWdata(cpuWdata),
        .cpuReady(cpuReady), .cpuDone(cpuDone), .cpuRdata(cpuRdata), .periphWide(periphWide),
        .extWide(extWide), .extThreeState(extThreeState), .extWaitCount(extWaitCount),
        .memSel(memSel), .periphSel(periphSel), .extSel(extSel), .busStart(busStart),
        .busAddr(busAddr), .busWrite(busWrite), .busLanes(busLanes), .busWdata(busWdata),
        .busRdata(busRdata));

    cbc_far_model u_far (.clk(clk), .anySel(memSel | periphSel | extSel), .narrow(narrow),
        .busAddr(busAddr), .busRdata(busRdata));

    // Byte stored at an address
    function automatic logic [7:0] fb(input logic [23:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction : fb

    // One access: pulse the request, count states and byte cycles
    task automatic run(input cbc_row_s r);
        int n;
        int starts;
        logic [15:0] exp;
        logic [15:0] wd;
        logic [1:0] ln;
        logic [23:0] ad;
        logic [2:0] sel;
        exp = r.word ? {fb({r.addr[23:1], 1'b0}), fb({r.addr[23:1], 1'b1})} : {8'h00, fb(r.addr)};
        @(negedge clk);
        cpuTarget = r.tgt;
        cpuAddr = r.addr;
        cpuWrite = r.wr;
        cpuWord = r.word;
        cpuWdata = {r.addr[7:0], ~r.addr[7:0]};
        periphWide = r.wide;
        extWide = r.wide;
        extThreeState = r.three;
        extWaitCount = r.m;
        cpuReq = 1'b1;
        `CHK("ready", 1'b1, cpuReady)
        @(negedge clk);
        cpuReq = 1'b0;
        n = 1;
        starts = 0;
        // First bus cycle: lanes, data and address follow width and alignment
        sel = {r.tgt == TGT_MEM, r.tgt == TGT_PERIPH, r.tgt == TGT_EXT};
        wd = {8'h00, ~r.addr[7:0]};
        ln = LANES_LOW;
        ad = r.word ? {r.addr[23:1], 1'b0} : r.addr;
        if (r.word && r.wide)
        begin
            wd = {r.addr[7:0], ~r.addr[7:0]};
            ln = LANES_BOTH;
        end
        else if (r.word)
        begin
            wd = {8'h00, r.addr[7:0]};
        end
        else if (r.wide && !r.addr[0])
        begin
            wd = {~r.addr[7:0], 8'h00};
            ln = LANES_HIGH;
        end
        // Bounded wait for done
        while (cpuDone !== 1'b1 && n < 40)
        begin
            starts += (busStart === 1'b1);
            if (busStart === 1'b1)
            begin
                `CHK("lanes", ln, busLanes)
                `CHK("direction", r.wr, busWrite)
                `CHK("select", sel, {memSel, periphSel, extSel})
                `CHK("address", ad, busAddr)
                if (r.wr)
                    `CHK("wdata", wd, busWdata)
                // A split word's second cycle: odd address, lower byte
                wd = {8'h00, ~r.addr[7:0]};
                ad = {r.addr[23:1], 1'b1};
            end
            @(negedge clk);
            n++;
        end
        `CHK("states", r.t, n - 1)
        `CHK("cycles", (r.word && !r.wide) ? 2 : 1, starts)
        `CHK("ready at done", 1'b1, cpuReady)
        `CHK("lanes at done", LANES_NONE, busLanes)
        `CHK("select at done", 3'h0, {memSel, periphSel, extSel})
        if (!r.wr)
            `CHK("rdata", exp, cpuRdata)
    endtask : run

    // Verdict and end of run
    task automatic end_sim;
        if (nFail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Hang guard, far beyond the expected run
    initial
    begin
        #20000;
        nFail++;
        end_sim();
    end

    initial
    begin
        rst_b = 1'b0;
        cpuReq = 1'b0;
        cpuTarget = TGT_MEM;
        cpuAddr = 24'h000000;
        cpuWrite = 1'b0;
        cpuWord = 1'b0;
        cpuWdata = 16'h0000;
        periphWide = 1'b0;
        extWide = 1'b0;
        extThreeState = 1'b0;
        extWaitCount = 3'h0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i])
            run(rows[i]);
        // Reset during a long split word must abandon it
        run('{TGT_EXT, 0, 1, 7, 1, 0, 24'h2000b8, 20});
        @(negedge clk);
        cpuReq = 1'b1;
        @(negedge clk);
        cpuReq = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b0;
        #1;
        `CHK("ready in reset", 1'b1, cpuReady)
        `CHK("select in reset", 1'b0, extSel)
        `CHK("start in reset", 1'b0, busStart)
        @(negedge clk);
        rst_b = 1'b1;
        run(rows[0]);
        end_sim();
    end
endmodule : tb_cpu_bus_cycle_timing
